// ===== rtl/rtg_top.sv
`timescale 1ns/10ps
module rtg_top
   import rtg_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata_q,
   output logic pready_q,
   output logic pslverr_q,
   input wire logic receive_idle_flag,
   output logic rate_tick_q,
   output logic bit_tick_q
);

   // ************************************************************
   // Register bus decode
   // ************************************************************
   logic [RTG_CTRL_W-1:0] ctrl_q;
   logic [RTG_CTRL_W-1:0] ctrl_d;
   logic [7:0] div_lo_q;
   logic [7:0] div_lo_d;
   logic [7:0] div_hi_q;
   logic [7:0] div_hi_d;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [31:0] rd_mux;
   logic setup;
   logic access;
   logic wr;
   logic hit;
   logic ctrl_wr;
   logic div_lo_wr;
   logic div_hi_wr;
   logic div_wr;

   // Phases of an APB transfer
   assign setup = psel && !penable;
   assign access = psel && penable && pready_q;
   assign wr = access && pwrite;
   assign hit = (paddr == RTG_OFS_CTRL) || (paddr == RTG_OFS_DIV_LO) ||
                (paddr == RTG_OFS_DIV_HI) || (paddr == RTG_OFS_STATUS) ||
                (paddr == RTG_OFS_COUNT);
   assign ctrl_wr = wr && (paddr == RTG_OFS_CTRL);
   assign div_lo_wr = wr && (paddr == RTG_OFS_DIV_LO);
   assign div_hi_wr = wr && (paddr == RTG_OFS_DIV_HI);
   assign div_wr = div_lo_wr || div_hi_wr;

   // Next register values
   assign ctrl_d = ctrl_wr ? pwdata[RTG_CTRL_W-1:0] : ctrl_q;
   assign div_lo_d = div_lo_wr ? pwdata[7:0] : div_lo_q;
   assign div_hi_d = div_hi_wr ? pwdata[7:0] : div_hi_q;

   // Read data selection
   assign rd_mux = (paddr == RTG_OFS_CTRL) ? {28'h000_0000, ctrl_q} :
                   (paddr == RTG_OFS_DIV_LO) ? {24'h00_0000, div_lo_q} :
                   (paddr == RTG_OFS_DIV_HI) ? {24'h00_0000, div_hi_q} :
                   (paddr == RTG_OFS_STATUS) ? {30'h0000_0000,
                      ctrl_q[RTG_CTRL_WIDE], receive_idle_flag} :
                   (paddr == RTG_OFS_COUNT) ? {16'h0000, cnt_q} :
                   32'h0000_0000;

   // Bus answer: ready in the first access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end
      else
      begin
         pready_q <= setup;
         pslverr_q <= setup && !hit;
         prdata_q <= setup ? rd_mux : prdata_q;
      end
   end

   // Control and divisor registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q <= RTG_CTRL_RST;
         div_lo_q <= RTG_DIV_RST;
         div_hi_q <= RTG_DIV_RST;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         div_lo_q <= div_lo_d;
         div_hi_q <= div_hi_d;
      end
   end

   // ************************************************************
   // Rate timer
   // ************************************************************
   logic [15:0] eff_q;
   logic [15:0] eff_d;
   logic restart;
   logic tmr_zero;
   logic run;
   logic [6:0] mult;

   // Effective divisor: high byte only counts in wide mode
   function automatic logic [15:0] eff_div(input logic wide, input logic [7:0] hi,
                                           input logic [7:0] lo);
      eff_div = wide ? {hi, lo} : {8'h00, lo};
   endfunction

   // Multiplier from mode bits; sync ignores high speed
   function automatic logic [6:0] mult_sel(input logic sync, input logic wide,
                                           input logic high);
      if (sync)
         mult_sel = RTG_MULT_FAST;
      else if (!wide && !high)
         mult_sel = RTG_MULT_SLOW;
      else if (wide && high)
         mult_sel = RTG_MULT_FAST;
      else
         mult_sel = RTG_MULT_MID;
   endfunction

   assign eff_q = eff_div(ctrl_q[RTG_CTRL_WIDE], div_hi_q, div_lo_q);
   assign eff_d = eff_div(ctrl_d[RTG_CTRL_WIDE], div_hi_d, div_lo_d);
   assign mult = mult_sel(ctrl_q[RTG_CTRL_SYNC], ctrl_q[RTG_CTRL_WIDE],
                          ctrl_q[RTG_CTRL_HIGH]);
   assign run = ctrl_q[RTG_CTRL_EN];
   assign restart = div_wr || ctrl_wr || !run;
   assign tmr_zero = (cnt_q == 16'h0000);
   // Down count with automatic reload
   assign cnt_d = restart ? eff_d : (tmr_zero ? eff_q : cnt_q - 16'h0001);

   // Timer count and rate tick
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q <= RTG_CNT_RST;
         rate_tick_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         rate_tick_q <= !restart && tmr_zero;
      end
   end

   // Bit ticks for transmitter and receiver
   rtg_bit_div #(
      .PRE_W(7)
   ) i_rtg_bit_div (
      .pclk(pclk),
      .presetn(presetn),
      .clear(restart),
      .rate_tick(rate_tick_q),
      .mult(mult),
      .bit_tick_q(bit_tick_q)
   );

   // ************************************************************
   // Checks
   // ************************************************************
   logic [16:0] gap_q;
   logic seen_q;

   // Cycles since the last rate tick
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gap_q <= 17'h0_0000;
         seen_q <= 1'b0;
      end
      else
      begin
         gap_q <= rate_tick_q ? 17'h0_0001 : gap_q + 17'h0_0001;
         seen_q <= restart ? 1'b0 : (rate_tick_q ? 1'b1 : seen_q);
      end
   end

   narrow_count_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_q[RTG_CTRL_WIDE] |-> (cnt_q[15:8] == 8'h00))
      else $error("8-bit mode count above 255");

   wide_divisor_a: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_q[RTG_CTRL_WIDE] && !restart |=> (cnt_q <= {div_hi_q, div_lo_q}))
      else $error("16-bit count outside divisor range");

   tick_period_a: assert property (@(posedge pclk) disable iff (!presetn)
      rate_tick_q && seen_q |-> (gap_q == {1'b0, eff_q} + 17'h0_0001))
      else $error("Rate tick period is not divisor plus one");

   divisor_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
      div_wr |=> (cnt_q == eff_q) ##1 (rate_tick_q == (run && (eff_q == 16'h0000))))
      else $error("Divisor write did not restart timer");

   tick_single_a: assert property (@(posedge pclk) disable iff (!presetn)
      rate_tick_q && (eff_q != 16'h0000) |=> !rate_tick_q)
      else $error("Rate tick longer than one cycle");

   sync_mult_a: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_q[RTG_CTRL_SYNC] |-> (mult == RTG_MULT_FAST))
      else $error("Sync mode multiplier depends on high speed");

   async_slow_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_q[RTG_CTRL_SYNC] && !ctrl_q[RTG_CTRL_WIDE] && !ctrl_q[RTG_CTRL_HIGH]
      |-> (mult == RTG_MULT_SLOW))
      else $error("Async 8-bit low speed multiplier not 64");

   async_mult_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_q[RTG_CTRL_SYNC] && (ctrl_q[RTG_CTRL_WIDE] != ctrl_q[RTG_CTRL_HIGH])
      |-> (mult == RTG_MULT_MID))
      else $error("Async mixed mode multiplier not 16");

   single_timer_a: assert property (@(posedge pclk) disable iff (!presetn)
      bit_tick_q |-> $past(rate_tick_q, 1))
      else $error("Bit tick without rate tick");

   bus_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
      setup |=> pready_q)
      else $error("No ready in access cycle");

   wide_tick_c: cover property (@(posedge pclk) disable iff (!presetn)
      ctrl_q[RTG_CTRL_WIDE] && div_hi_q != 8'h00 && rate_tick_q && seen_q);
   sync_bit_c: cover property (@(posedge pclk) disable iff (!presetn)
      ctrl_q[RTG_CTRL_SYNC] && bit_tick_q);
   restart_run_c: cover property (@(posedge pclk) disable iff (!presetn)
      div_wr && run && cnt_q != 16'h0000);
   slow_bit_c: cover property (@(posedge pclk) disable iff (!presetn)
      mult == RTG_MULT_SLOW && bit_tick_q);

endmodule

// ===== include/rtg_pkg.sv
// ************************************************************
// Rate timer constants
// ************************************************************
package rtg_pkg;

   // Register byte offsets
   localparam logic [7:0] RTG_OFS_CTRL = 8'h00;
   localparam logic [7:0] RTG_OFS_DIV_LO = 8'h04;
   localparam logic [7:0] RTG_OFS_DIV_HI = 8'h08;
   localparam logic [7:0] RTG_OFS_STATUS = 8'h0C;
   localparam logic [7:0] RTG_OFS_COUNT = 8'h10;

   // Control field positions
   localparam int RTG_CTRL_WIDE = 0;
   localparam int RTG_CTRL_HIGH = 1;
   localparam int RTG_CTRL_SYNC = 2;
   localparam int RTG_CTRL_EN = 3;
   localparam int RTG_CTRL_W = 4;

   // Status field positions
   localparam int RTG_STAT_IDLE = 0;
   localparam int RTG_STAT_WIDE = 1;

   // Values after reset
   localparam logic [3:0] RTG_CTRL_RST = 4'h0;
   localparam logic [7:0] RTG_DIV_RST = 8'h00;
   localparam logic [15:0] RTG_CNT_RST = 16'h0000;

   // Bit period multipliers, in rate ticks per bit
   localparam logic [6:0] RTG_MULT_SLOW = 7'h40;
   localparam logic [6:0] RTG_MULT_MID = 7'h10;
   localparam logic [6:0] RTG_MULT_FAST = 7'h04;

endpackage

// ===== rtl/rtg_bit_div.sv
`timescale 1ns/10ps
// ************************************************************
// Bit period divider: rate ticks to bit ticks
// ************************************************************
module rtg_bit_div
   import rtg_pkg::*;
#(
   parameter int PRE_W = 7
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clear,
   input wire logic rate_tick,
   input wire logic [6:0] mult,
   output logic bit_tick_q
);

   logic [PRE_W-1:0] pre_q;
   logic [PRE_W-1:0] pre_d;
   logic wrap;

   // Wrap when the last rate tick of a bit arrives
   assign wrap = rate_tick && (pre_q == PRE_W'(mult - 7'h01));
   assign pre_d = clear ? '0 : (wrap ? '0 : (rate_tick ? pre_q + 1'b1 : pre_q));

   // Prescale count and bit tick
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pre_q <= '0;
         bit_tick_q <= 1'b0;
      end
      else
      begin
         pre_q <= pre_d;
         bit_tick_q <= wrap && !clear;
      end
   end

endmodule

// ===== tb/rtg_serial_model.sv
`timescale 1ns/10ps
// ************************************************************
// Far side: serial engine that consumes the ticks
// ************************************************************
module rtg_serial_model
(
   input wire logic pclk,
   input wire logic rx_busy,
   input wire logic rate_tick_q,
   input wire logic bit_tick_q,
   output logic receive_idle_flag,
   output int cyc,
   output int rcnt,
   output int bcnt,
   output int rt_at,
   output int rate_per,
   output int bit_per
);
   int bt_at;

   // Receiver reports idle whenever no frame is in progress
   assign receive_idle_flag = !rx_busy;

   // Tick counts and spacing, in pclk cycles
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (rate_tick_q)
      begin
         rcnt <= rcnt + 1;
         rt_at <= cyc;
         rate_per <= cyc - rt_at;
      end
      if (bit_tick_q)
      begin
         bcnt <= bcnt + 1;
         bt_at <= cyc;
         bit_per <= cyc - bt_at;
      end
   end
endmodule

// ===== tb/rtg_top_tb_top.sv
`timescale 1ns/10ps
// ************************************************************
// Bench for the rate timer
// ************************************************************
module rtg_top_tb_top
   import rtg_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, rx_busy, b;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata_q;
   logic pready_q, pslverr_q, receive_idle_flag, rate_tick_q, bit_tick_q;
   logic [32:0] exp_q[$];
   logic [32:0] e;
   logic [2:0] m;
   int cyc, rcnt, bcnt, rt_at, rate_per, bit_per, fail_count, num_checks;
   int n, t, w, mult, tmo;

   // Free running clock, 8 ns period
   initial
   begin
      pclk = 0;
      forever #4 pclk = ~pclk;
   end

   rtg_top i_rtg_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
      .pready_q(pready_q), .pslverr_q(pslverr_q), .receive_idle_flag(receive_idle_flag),
      .rate_tick_q(rate_tick_q), .bit_tick_q(bit_tick_q));

   rtg_serial_model i_rtg_serial_model (.pclk(pclk), .rx_busy(rx_busy),
      .rate_tick_q(rate_tick_q), .bit_tick_q(bit_tick_q),
      .receive_idle_flag(receive_idle_flag), .cyc(cyc), .rcnt(rcnt), .bcnt(bcnt),
      .rt_at(rt_at), .rate_per(rate_per), .bit_per(bit_per));

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task check(input logic [32:0] seen, input logic [32:0] expv);
      num_checks++;
      if (seen !== expv)
      begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask

   task conclude;
      $display("checks=%0d fails=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // One APB transfer; a read notes its expected {error, data}
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] ex);
      if (!wr)
         exp_q.push_back(ex);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (!pready_q)
         @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Read monitor compares against the oldest note
   always @(posedge pclk)
   begin
      if (psel && penable && pready_q && !pwrite)
      begin
         e = exp_q.pop_front();
         check({pslverr_q, prdata_q}, e);
      end
   end

   // Hang guard
   always @(posedge pclk)
   begin
      tmo++;
      if (tmo == 80000)
      begin
         fail_count++;
         conclude;
      end
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial
   begin
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      rx_busy = 0;
      presetn = 0;
      void'($urandom(32'h4e840c76));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, RTG_OFS_CTRL, 0, 33'h0_0000_0000);
      apb(0, RTG_OFS_DIV_LO, 0, 33'h0_0000_0000);
      apb(0, RTG_OFS_COUNT, 0, 33'h0_0000_0000);
      apb(0, 8'h14, 0, 33'h1_0000_0000);
      // Every mode: sync, high speed, width
      for (int i = 0; i < 8; i++)
      begin
         m = 3'(i);
         n = $urandom_range(20, 2);
         b = 1'($urandom_range(1, 0));
         rx_busy <= b;
         apb(1, RTG_OFS_DIV_HI, 32'h0000_0001, 0);
         apb(1, RTG_OFS_DIV_LO, 32'(n), 0);
         apb(1, RTG_OFS_CTRL, {28'h0, 1'b1, m}, 0);
         apb(0, RTG_OFS_STATUS, 0, {31'h0, m[0], !b});
         t = m[0] ? 256 + n : n;
         mult = (m[2] || (m[0] && m[1])) ? 4 : ((m[0] ^ m[1]) ? 16 : 64);
         w = bcnt;
         wait (bcnt >= w + 2);
         @(posedge pclk);
         check(33'(rate_per), 33'(t + 1));
         check(33'(bit_per), 33'(mult * (t + 1)));
      end
      // Divisor rewrite mid-count restarts at once
      rx_busy <= 1'b0;
      apb(1, RTG_OFS_CTRL, 32'h0000_0008, 0);
      apb(1, RTG_OFS_DIV_LO, 32'h0000_00C8, 0);
      repeat (50) @(posedge pclk);
      apb(1, RTG_OFS_DIV_LO, 32'h0000_0003, 0);
      t = cyc;
      w = rcnt;
      wait (rcnt > w);
      @(posedge pclk);
      check(33'(rt_at - t), 33'h4);
      apb(1, RTG_OFS_DIV_HI, 32'h0000_0005, 0);
      w = rcnt;
      wait (rcnt >= w + 2);
      @(posedge pclk);
      check(33'(rate_per), 33'h4);
      apb(1, RTG_OFS_DIV_LO, 32'h0000_0000, 0);
      repeat (6) @(posedge pclk);
      check(33'(rate_per), 33'h1);
      apb(1, RTG_OFS_CTRL, 32'h0000_0000, 0);
      w = rcnt;
      repeat (100) @(posedge pclk);
      check(33'(rcnt - w), 33'h0);
      // Stopped timer follows a new divisor at once
      apb(1, RTG_OFS_DIV_LO, 32'h0000_002A, 0);
      apb(0, RTG_OFS_COUNT, 0, 33'h0_0000_002A);
      conclude;
   end
endmodule
